// >>> hw/csp_pkg.sv
// Summary of operation
// - Status at 03h: page, watchdog, sleep, Z, nibble, C.
// - Watchdog flag one at reset, cleared on expiry.
// - Kick or sleep instruction sets watchdog flag.
// - Sleep flag: reset one, sleep clears, kick sets.
// - Watchdog and sleep flags ignore status writes.
// - Page bits feed jumps; page instruction touches only them.
// - Zero flag follows result of arithmetic, file move (OP_MOVF), logic.
// - Nibble carry: add carry sets, subtract borrow clears.
// - Carry: add carry sets, subtract borrow clears.
// - Carry input enable adds carry into arithmetic.
// - By default carry is not an arithmetic input.
// - Rotate right loads bit 0, left bit 7.
// - Pointer at 04h; semi-direct uses its bank bits.
// - Address 00h reaches the register the pointer names.
// - Port data at 05h-09h drive the port outputs.
// - Port reads return pin levels by default.
// - Port read source bit picks pins or registers.
// - Pointer 00h-0Fh is global; higher is banks 1-F.
package csp_pkg;
   // ==========================================================
   // Bus layout.
   localparam int AXI_AW = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // Register indices; byte address is four times the index.
   localparam logic [5:0] IDX_STATUS = 6'h03;
   localparam logic [5:0] IDX_FSP = 6'h04;
   localparam logic [5:0] IDX_PORT_A = 6'h05;
   localparam logic [5:0] IDX_CTRL = 6'h10;
   localparam logic [5:0] IDX_CMD = 6'h11;
   localparam logic [5:0] IDX_RESULT = 6'h12;
   // ==========================================================
   // Status fields.
   localparam int SB_WDOG = 4;
   localparam int SB_SLEEP = 3;
   localparam int SB_Z = 2;
   localparam int SB_NIB = 1;
   localparam int SB_C = 0;
   localparam logic [7:0] STATUS_WR_MASK = 8'hE7;
   localparam logic [7:0] STATUS_RESET = 8'h18;
   // ==========================================================
   // Control fields.
   localparam int CTRL_CIE = 0;
   localparam int CTRL_PRS = 1;
   localparam logic [7:0] CTRL_RESET = 8'h02;
   // ==========================================================
   // Command fields and file addresses.
   localparam int CMD_TO_W = 4;
   localparam logic [3:0] FA_NULL = 4'h0;
   localparam logic [3:0] FA_STATUS = 4'h3;
   localparam logic [3:0] FA_FSP = 4'h4;
   localparam logic [3:0] FA_PORT_A = 4'h5;
   localparam int RAM_AW = 9;
   typedef enum logic [3:0] {
      OP_MOVF = 4'h0, OP_MOVWF = 4'h1, OP_ADD = 4'h2, OP_SUB = 4'h3,
      OP_INC = 4'h4, OP_DEC = 4'h5, OP_AND = 4'h6, OP_OR = 4'h7,
      OP_XOR = 4'h8, OP_ROR = 4'h9, OP_ROL = 4'hA, OP_KICK = 4'hB,
      OP_SLEEP = 4'hC, OP_PAGE = 4'hD, OP_MOVLW = 4'hE, OP_NOP = 4'hF
   } csp_op_t;
   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC} csp_state_t;
endpackage

// >>> hw/csp_ram.sv
`timescale 1ns/1ps
module csp_ram
#(
   parameter int AW = 9,
   parameter int DW = 8
)
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_b,
   // Write side.
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // Read side.
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata_ff
);
   logic [DW-1:0] mem [2**AW];

   always_ff @(posedge ref_clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rdata_ff <= '0;
      end
      else
      begin
         rdata_ff <= mem[raddr];
      end
   end
endmodule

// >>> hw/csp_alu.sv
`timescale 1ns/1ps
module csp_alu
(
   // Operation.
   input wire csp_pkg::csp_op_t op,
   input wire logic to_w,
   // Operands.
   input wire logic [7:0] a,
   input wire logic [7:0] w,
   input wire logic [7:0] lit,
   input wire logic c_in,
   input wire logic cie,
   // Results.
   output logic [7:0] res,
   output logic wr_file,
   output logic wr_w,
   output logic z_upd,
   output logic z,
   output logic nc_upd,
   output logic nc,
   output logic c_upd,
   output logic c
);
   logic sub;
   logic cin;
   logic [7:0] bb;
   logic [4:0] lo5;
   logic [8:0] full;

   always_comb
   begin
      sub = (op == csp_pkg::OP_SUB);
      bb = sub ? ~w : w;
      // Subtraction adds the inverse, so carry out means no borrow.
      cin = cie ? c_in : sub;
      lo5 = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
      full = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
      res = a;
      wr_file = 1'b0;
      wr_w = 1'b0;
      z_upd = 1'b0;
      nc_upd = 1'b0;
      c_upd = 1'b0;
      c = c_in;
      nc = lo5[4];
      unique case (op)
         csp_pkg::OP_ADD, csp_pkg::OP_SUB:
         begin
            res = full[7:0];
            c = full[8];
            z_upd = 1'b1;
            nc_upd = 1'b1;
            c_upd = 1'b1;
         end
         csp_pkg::OP_MOVF: z_upd = 1'b1;
         csp_pkg::OP_INC:
         begin
            res = a + 8'h01;
            z_upd = 1'b1;
         end
         csp_pkg::OP_DEC:
         begin
            res = a - 8'h01;
            z_upd = 1'b1;
         end
         csp_pkg::OP_AND:
         begin
            res = a & w;
            z_upd = 1'b1;
         end
         csp_pkg::OP_OR:
         begin
            res = a | w;
            z_upd = 1'b1;
         end
         csp_pkg::OP_XOR:
         begin
            res = a ^ w;
            z_upd = 1'b1;
         end
         csp_pkg::OP_ROR:
         begin
            res = {c_in, a[7:1]};
            c = a[0];
            c_upd = 1'b1;
         end
         csp_pkg::OP_ROL:
         begin
            res = {a[6:0], c_in};
            c = a[7];
            c_upd = 1'b1;
         end
         csp_pkg::OP_MOVWF: res = w;
         csp_pkg::OP_MOVLW: res = lit;
         csp_pkg::OP_KICK, csp_pkg::OP_SLEEP, csp_pkg::OP_PAGE,
         csp_pkg::OP_NOP: res = a;
      endcase
      z = (res == 8'h00);
      if (op == csp_pkg::OP_MOVWF)
      begin
         wr_file = 1'b1;
      end
      else if (op == csp_pkg::OP_MOVLW)
      begin
         wr_w = 1'b1;
      end
      else if (op < csp_pkg::OP_KICK)
      begin
         wr_w = to_w;
         wr_file = ~to_w;
      end
   end
endmodule

// >>> hw/csp_regs.sv
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module csp_regs
#(
   parameter int N_PORTS = 5
)
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_b,
   // AXI4-Lite write address and data.
   input wire logic [csp_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read.
   input wire logic [csp_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Port pins and core signals.
   input wire logic [8*N_PORTS-1:0] port_pin_in,
   output logic [8*N_PORTS-1:0] port_out,
   input wire logic wdt_expire,
   output logic [2:0] page_select_bits
);
   // ==========================================================
   // Declarations.
   csp_pkg::csp_state_t state_ff;
   csp_pkg::csp_state_t nxt_state;
   csp_pkg::csp_op_t op;
   logic [7:0] status_ff;
   logic [7:0] nxt_status;
   logic [7:0] fsp_ff;
   logic [7:0] ctrl_ff;
   logic [7:0] w_ff;
   logic [23:0] cmd_ff;
   logic awready_ff;
   logic wready_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic arready_ff;
   logic rvalid_ff;
   logic [1:0] rresp_ff;
   logic [31:0] rdata_ff;
   logic [7:0] port_ff [N_PORTS];
   logic [7:0] port_rd [N_PORTS];
   logic [5:0] wr_idx;
   logic [5:0] rd_idx;
   logic wr_fire;
   logic wr_map;
   logic wr_en;
   logic [31:0] rd_word;
   logic rd_map;
   logic is_global;
   logic [3:0] bank;
   logic [3:0] lo;
   logic [csp_pkg::RAM_AW-1:0] ram_addr;
   logic [7:0] ram_rdata;
   logic [7:0] file_rd;
   logic hit_special;
   logic exec;
   logic [7:0] alu_res;
   logic alu_wr_file;
   logic alu_wr_w;
   logic z_upd;
   logic z_val;
   logic nc_upd;
   logic nc_val;
   logic c_upd;
   logic c_val;
   logic file_we;

   // ==========================================================
   // Outputs.
   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp = rresp_ff;
   assign s_axi_rdata = rdata_ff;
   assign page_select_bits = status_ff[7:5];

   // ==========================================================
   // Write channel. Writes are taken only while idle, so an
   // instruction never races a bus write for the same register.
   assign wr_idx = s_axi_awaddr[7:2];
   assign wr_fire = awready_ff & s_axi_awvalid & s_axi_wvalid;
   assign wr_map = (wr_idx == csp_pkg::IDX_STATUS)
      || (wr_idx == csp_pkg::IDX_FSP)
      || ((wr_idx >= csp_pkg::IDX_PORT_A)
         && (wr_idx < csp_pkg::IDX_PORT_A + 6'(N_PORTS)))
      || (wr_idx == csp_pkg::IDX_CTRL)
      || (wr_idx == csp_pkg::IDX_CMD);
   assign wr_en = wr_fire & wr_map & s_axi_wstrb[0];

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
      end
      else
      begin
         awready_ff <= s_axi_awvalid & s_axi_wvalid & ~awready_ff
            & ~bvalid_ff & (state_ff == csp_pkg::ST_IDLE);
         wready_ff <= s_axi_awvalid & s_axi_wvalid & ~awready_ff
            & ~bvalid_ff & (state_ff == csp_pkg::ST_IDLE);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bvalid_ff <= 1'b0;
         bresp_ff <= csp_pkg::RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_ff <= 1'b1;
         bresp_ff <= wr_map ? csp_pkg::RESP_OKAY : csp_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         bvalid_ff <= 1'b0;
      end
   end

   // ==========================================================
   // Read channel.
   assign rd_idx = s_axi_araddr[7:2];

   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_map = 1'b1;
      if (rd_idx == csp_pkg::IDX_STATUS)
      begin
         rd_word[7:0] = status_ff;
      end
      else if (rd_idx == csp_pkg::IDX_FSP)
      begin
         rd_word[7:0] = fsp_ff;
      end
      else if (rd_idx == csp_pkg::IDX_CTRL)
      begin
         rd_word[7:0] = ctrl_ff;
      end
      else if (rd_idx == csp_pkg::IDX_CMD)
      begin
         rd_word[23:0] = cmd_ff;
      end
      else if (rd_idx == csp_pkg::IDX_RESULT)
      begin
         rd_word[8] = (state_ff != csp_pkg::ST_IDLE);
         rd_word[7:0] = w_ff;
      end
      else
      begin
         rd_map = 1'b0;
      end
      for (int i = 0; i < N_PORTS; i++)
      begin
         if (rd_idx == csp_pkg::IDX_PORT_A + 6'(i))
         begin
            rd_word[7:0] = port_rd[i];
            rd_map = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         arready_ff <= 1'b0;
      end
      else
      begin
         arready_ff <= s_axi_arvalid & ~arready_ff & ~rvalid_ff;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rvalid_ff <= 1'b0;
         rresp_ff <= csp_pkg::RESP_OKAY;
         rdata_ff <= 32'h0000_0000;
      end
      else if (arready_ff && s_axi_arvalid)
      begin
         rvalid_ff <= 1'b1;
         rresp_ff <= rd_map ? csp_pkg::RESP_OKAY : csp_pkg::RESP_SLVERR;
         rdata_ff <= rd_word;
      end
      else if (s_axi_rready)
      begin
         rvalid_ff <= 1'b0;
      end
   end

   // ==========================================================
   // Instruction sequencing: fetch the operand, then execute.
   assign exec = (state_ff == csp_pkg::ST_EXEC);
   assign op = csp_pkg::csp_op_t'(cmd_ff[3:0]);

   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         csp_pkg::ST_IDLE:
            if (wr_en && (wr_idx == csp_pkg::IDX_CMD))
            begin
               nxt_state = csp_pkg::ST_FETCH;
            end
         csp_pkg::ST_FETCH: nxt_state = csp_pkg::ST_EXEC;
         csp_pkg::ST_EXEC: nxt_state = csp_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_ff <= csp_pkg::ST_IDLE;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cmd_ff <= {16'h0000, 8'h0F};
      end
      else if (wr_en && (wr_idx == csp_pkg::IDX_CMD))
      begin
         cmd_ff <= s_axi_wdata[23:0];
      end
   end

   // ==========================================================
   // File address resolution.
   always_comb
   begin
      if (cmd_ff[12:8] == 5'h00)
      begin
         is_global = (fsp_ff[7:4] == 4'h0);
         bank = fsp_ff[7:4];
         lo = fsp_ff[3:0];
      end
      else if (cmd_ff[12])
      begin
         is_global = 1'b0;
         bank = fsp_ff[7:4];
         lo = cmd_ff[11:8];
      end
      else
      begin
         is_global = 1'b1;
         bank = 4'h0;
         lo = cmd_ff[11:8];
      end
      ram_addr = {is_global, bank, lo};
      hit_special = is_global && ((lo == csp_pkg::FA_NULL)
         || ((lo >= csp_pkg::FA_STATUS)
         && (lo < csp_pkg::FA_PORT_A + 4'(N_PORTS))));
      file_rd = ram_rdata;
      if (is_global && (lo == csp_pkg::FA_NULL))
      begin
         file_rd = 8'h00;
      end
      else if (is_global && (lo == csp_pkg::FA_STATUS))
      begin
         file_rd = status_ff;
      end
      else if (is_global && (lo == csp_pkg::FA_FSP))
      begin
         file_rd = fsp_ff;
      end
      for (int i = 0; i < N_PORTS; i++)
      begin
         if (is_global && (lo == csp_pkg::FA_PORT_A + 4'(i)))
         begin
            file_rd = port_rd[i];
         end
      end
   end

   csp_ram #(.AW(csp_pkg::RAM_AW), .DW(8)) u_ram
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .we(file_we & ~hit_special),
      .waddr(ram_addr),
      .wdata(alu_res),
      .raddr(ram_addr),
      .rdata_ff(ram_rdata)
   );

   csp_alu u_alu
   (
      .op(op),
      .to_w(cmd_ff[csp_pkg::CMD_TO_W]),
      .a(file_rd),
      .w(w_ff),
      .lit(cmd_ff[23:16]),
      .c_in(status_ff[csp_pkg::SB_C]),
      .cie(ctrl_ff[csp_pkg::CTRL_CIE]),
      .res(alu_res),
      .wr_file(alu_wr_file),
      .wr_w(alu_wr_w),
      .z_upd(z_upd),
      .z(z_val),
      .nc_upd(nc_upd),
      .nc(nc_val),
      .c_upd(c_upd),
      .c(c_val)
   );

   assign file_we = exec & alu_wr_file;

   // ==========================================================
   // Status register.
   always_comb
   begin
      nxt_status = status_ff;
      if (wr_en && (wr_idx == csp_pkg::IDX_STATUS))
      begin
         nxt_status = (s_axi_wdata[7:0] & csp_pkg::STATUS_WR_MASK)
            | (status_ff & ~csp_pkg::STATUS_WR_MASK);
      end
      if (file_we && is_global && (lo == csp_pkg::FA_STATUS))
      begin
         nxt_status = (alu_res & csp_pkg::STATUS_WR_MASK)
            | (status_ff & ~csp_pkg::STATUS_WR_MASK);
      end
      // Flag updates come after the data write so they win.
      if (exec && z_upd)
      begin
         nxt_status[csp_pkg::SB_Z] = z_val;
      end
      if (exec && nc_upd)
      begin
         nxt_status[csp_pkg::SB_NIB] = nc_val;
      end
      if (exec && c_upd)
      begin
         nxt_status[csp_pkg::SB_C] = c_val;
      end
      if (exec && (op == csp_pkg::OP_PAGE))
      begin
         nxt_status[7:5] = cmd_ff[18:16];
      end
      if (exec && (op == csp_pkg::OP_KICK))
      begin
         nxt_status[csp_pkg::SB_WDOG] = 1'b1;
         nxt_status[csp_pkg::SB_SLEEP] = 1'b1;
      end
      if (exec && (op == csp_pkg::OP_SLEEP))
      begin
         nxt_status[csp_pkg::SB_WDOG] = 1'b1;
         nxt_status[csp_pkg::SB_SLEEP] = 1'b0;
      end
      // An expiry is a hardware event and is never lost.
      if (wdt_expire)
      begin
         nxt_status[csp_pkg::SB_WDOG] = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         status_ff <= csp_pkg::STATUS_RESET;
      end
      else
      begin
         status_ff <= nxt_status;
      end
   end

   // ==========================================================
   // Pointer, control and working registers.
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fsp_ff <= 8'h00;
      end
      else if (wr_en && (wr_idx == csp_pkg::IDX_FSP))
      begin
         fsp_ff <= s_axi_wdata[7:0];
      end
      else if (file_we && is_global && (lo == csp_pkg::FA_FSP))
      begin
         fsp_ff <= alu_res;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ctrl_ff <= csp_pkg::CTRL_RESET;
      end
      else if (wr_en && (wr_idx == csp_pkg::IDX_CTRL))
      begin
         ctrl_ff <= s_axi_wdata[7:0] & csp_pkg::CTRL_RESET | s_axi_wdata[7:0]
            & 8'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         w_ff <= 8'h00;
      end
      else if (exec && alu_wr_w)
      begin
         w_ff <= alu_res;
      end
   end

   // ==========================================================
   // Ports. Pins are foreign to this clock, so two flops first.
   generate
      for (genvar p = 0; p < N_PORTS; p++)
      begin : g_port
         logic [7:0] pin_meta_ff;
         logic [7:0] pin_sync_ff;

         always_ff @(posedge ref_clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               pin_meta_ff <= 8'h00;
               pin_sync_ff <= 8'h00;
            end
            else
            begin
               pin_meta_ff <= port_pin_in[8*p +: 8];
               pin_sync_ff <= pin_meta_ff;
            end
         end

         always_ff @(posedge ref_clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               port_ff[p] <= 8'h00;
            end
            else if (wr_en && (wr_idx == csp_pkg::IDX_PORT_A + 6'(p)))
            begin
               port_ff[p] <= s_axi_wdata[7:0];
            end
            else if (file_we && is_global
               && (lo == csp_pkg::FA_PORT_A + 4'(p)))
            begin
               port_ff[p] <= alu_res;
            end
         end

         assign port_out[8*p +: 8] = port_ff[p];
         // Pins may lag a fresh write by the synchroniser delay.
         assign port_rd[p] = ctrl_ff[csp_pkg::CTRL_PRS] ? pin_sync_ff
            : port_ff[p];
      end
   endgenerate
endmodule

// >>> tb/csp_regs_properties.sv
`timescale 1ns/1ps
module csp_regs_properties
#(
   parameter int N_PORTS = 5
)
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_b,
   // Bus.
   input wire logic [csp_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Core.
   input wire logic [8*N_PORTS-1:0] port_out,
   input wire logic [2:0] page_select_bits
);
   // ==========
   // Bus checks.
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   sequence take(ix);
      s_axi_awready && s_axi_wstrb[0] && s_axi_awaddr[7:2] == ix;
   endsequence
   AST_PAIR:
      assert property (s_axi_awready |-> s_axi_wready && s_axi_wvalid)
         else $error("write halves split");
   AST_BRESP:
      assert property (s_axi_awready |=> ##[0:2] s_axi_bvalid)
         else $error("late write answer");
   AST_BHOLD:
      assert property (s_axi_bvalid && s_axi_bready |=>
         !s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp drop");
   AST_RANS:
      assert property (s_axi_arready |=> s_axi_rvalid)
         else $error("late read answer");
   AST_RHOLD:
      assert property (s_axi_rvalid && s_axi_rready |=>
         !s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata drop");
   AST_PAGE:
      assert property (take(6'h03) |=>
         page_select_bits == $past(s_axi_wdata[7:5])) else $error("page");
   AST_PORT:
      assert property (take(6'h05) |=>
         port_out[7:0] == $past(s_axi_wdata[7:0])) else $error("port");
   AST_NOSTRB:
      assert property (s_axi_awready && !s_axi_wstrb[0] |=>
         $stable(port_out)) else $error("masked write landed");
endmodule

bind csp_regs csp_regs_properties #(.N_PORTS(N_PORTS)) u_props (.*);

// >>> tb/cpu_status_pointer_port_regs_bench.sv
`timescale 1ns/1ps
module cpu_status_pointer_port_regs_bench;
   // ==========
   // Signals.
   localparam logic [5:0] ST = csp_pkg::IDX_STATUS;
   localparam logic [5:0] FP = csp_pkg::IDX_FSP;
   localparam logic [5:0] CT = csp_pkg::IDX_CTRL;
   localparam logic [5:0] RS = csp_pkg::IDX_RESULT;
   logic ref_clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, wdt_expire, s_axi_awready;
   logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [39:0] port_pin_in, port_out;
   logic [2:0] page_select_bits;
   int error_cnt, comparisons, cyc;
   csp_regs u_dut (.*);
   // ==========
   // Tasks.
   task automatic chk(input logic [31:0] g, e);
      comparisons++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic report_and_stop;
      $display("errors %0d compares %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic wr(input logic [5:0] x, input logic [31:0] d,
      input logic [1:0] r = 2'h0, input logic [3:0] s = 4'hF);
      s_axi_awaddr <= {x, 2'h0};
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do @(posedge ref_clk); while (s_axi_awready !== 1'h1);
      s_axi_awvalid <= 1'h0;
      s_axi_wvalid <= 1'h0;
      do @(posedge ref_clk); while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      chk(s_axi_bresp, r);
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [5:0] x, input logic [31:0] e,
      input logic [1:0] r = 2'h0);
      s_axi_araddr <= {x, 2'h0};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do @(posedge ref_clk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge ref_clk); while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      chk(s_axi_rresp, r);
      if (r == 2'h0)
         chk(s_axi_rdata, e);
      @(posedge ref_clk);
   endtask
   task automatic ins(input logic [3:0] op, input logic [4:0] f,
      input logic [7:0] l = 8'h00, input logic dw = 1'h1);
      wr(csp_pkg::IDX_CMD, {8'h00, l, 3'h0, f, 3'h0, dw, op});
   endtask
   // Status is rewritten first so every case starts from known flags.
   task automatic ar(input logic [39:0] v);
      wr(ST, {28'h0, v[35:32]});
      ins(4'hE, 5'h00, v[31:24]);
      ins(4'h1, 5'h10, 8'h00, 1'h0);
      ins(4'hE, 5'h00, v[23:16]);
      ins(v[39:36], 5'h10);
      rd(RS, {24'h0, v[15:8]});
      rd(ST, {24'h0, v[7:0]});
   endtask
   task automatic pchk(input logic [7:0] b);
      for (int i = 0; i < 5; i++)
         rd(6'h05 + 6'(i), {24'h0, b ^ 8'(i)});
   endtask
   // ==========
   // Run.
   localparam logic [39:0] TV [15] = '{
      40'h200F01101A, 40'h20F010001D, 40'h3010010F19, 40'h300102FF18,
      40'h300505001F, 40'h60F00F001C, 40'h805A5A001C, 40'h7101000119,
      40'h40FF00001C, 40'h510100001D, 40'h000033001C, 40'h9001000019,
      40'h9102008118, 40'hA180000119, 40'h2101010218};
   initial
   begin
      ref_clk = 1'h0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc > 6000)
      begin
         error_cnt++;
         report_and_stop;
      end
   end
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, wdt_expire, rst_b} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      port_pin_in = '0;
      repeat (5) @(posedge ref_clk);
      rst_b <= 1'h1;
      @(posedge ref_clk);
      rd(ST, 32'h18);
      rd(FP, 32'h00);
      rd(CT, 32'h02);
      wr(ST, 32'h00);
      rd(ST, 32'h18);
      wr(ST, 32'hE7);
      rd(ST, 32'hFF);
      ins(4'hD, 5'h00, 8'h02);
      rd(ST, 32'h5F);
      chk(page_select_bits, 3'h2);
      foreach (TV[i]) ar(TV[i]);
      wr(CT, 32'h03);
      ar(40'h2101010318);
      ar(40'h300505FF18);
      wr(CT, 32'h02);
      wr(ST, 32'h00);
      ins(4'h5, 5'h03, 8'h00, 1'h0);
      rd(ST, 32'h1B);
      wr(FP, 32'h25);
      ins(4'hE, 5'h00, 8'h5A);
      ins(4'h1, 5'h15, 8'h00, 1'h0);
      wr(FP, 32'h2F);
      ins(4'h0, 5'h15);
      rd(RS, 32'h5A);
      wr(FP, 32'h25);
      ins(4'hE, 5'h00, 8'h00);
      ins(4'h0, 5'h00);
      rd(RS, 32'h5A);
      wr(FP, 32'h05);
      ins(4'hE, 5'h00, 8'h3C);
      ins(4'h1, 5'h00, 8'h00, 1'h0);
      // The instruction lands on the edge at which the task returns.
      @(posedge ref_clk);
      chk(port_out[7:0], 8'h3C);
      wr(csp_pkg::IDX_PORT_A, 32'hFF, 2'h0, 4'h0);
      chk(port_out[7:0], 8'h3C);
      wr(6'h3F, 32'h0, 2'h2);
      rd(6'h3F, 32'h0, 2'h2);
      wr(RS, 32'h0, 2'h2);
      for (int i = 0; i < 5; i++)
      begin
         wr(6'h05 + 6'(i), {24'h0, 8'hC0 ^ 8'(i)});
         chk(port_out[8*i+:8], 8'hC0 ^ 8'(i));
         port_pin_in[8*i+:8] <= 8'h3C ^ 8'(i);
      end
      // Pins pass two sync flops before a read can see them.
      repeat (3) @(posedge ref_clk);
      pchk(8'h3C);
      wr(CT, 32'h00);
      pchk(8'hC0);
      wr(ST, 32'h00);
      wdt_expire <= 1'h1;
      @(posedge ref_clk);
      wdt_expire <= 1'h0;
      rd(ST, 32'h08);
      ins(4'hC, 5'h00);
      rd(ST, 32'h10);
      ins(4'hB, 5'h00);
      rd(ST, 32'h18);
      report_and_stop;
   end
endmodule
